// ===== occg_clock_gen.sv
// Register access over Wishbone is this design's own decision.
module occg_clock_gen #(
    parameter int WAKE_CYCLES = occg_pkg::WAKE_US * occg_pkg::CLK_MHZ
) (
    // clock and resets
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        porRst_b,
    // nonvolatile configuration and system
    input  wire logic [2:0]  cfgSource,
    input  wire logic        rtcUsesCrystal,
    input  wire logic        wakeReq,
    // oscillator sources
    input  wire logic        crystalClock,
    input  wire logic        rcOscillatorClock,
    input  wire logic        watchdogOscClock,
    input  wire logic        crystalInputPin,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // clock enables and analog controls
    output logic             cpuCoreClockEn,
    output logic             periphClock,
    output logic             machineCycleEn,
    output logic [5:0]       rcTune,
    output logic [1:0]       crystalSpeed,
    output logic             crystalEnable,
    // crystal output pin
    output logic             crystalOutputPin,
    output logic             crystalOutputOe_b
);

    typedef struct packed {
        // configuration
        logic                 cfgLoaded;
        occg_pkg::occg_src_t  srcSel;

        // input synchronisers and edge detect
        logic [4:0]           sync1;
        logic [4:0]           sync2;
        logic                 oscPrev;

        // cpu clock divider
        logic [7:0]           divN;
        logic [8:0]           divCnt;

        // wake-up timer
        occg_pkg::occg_wake_t wake;
        logic [9:0]           wakeOsc;
        logic [15:0]          wakeTime;

        // derived clock enables
        logic                 cpuTick;
        logic                 periphClk;
        logic                 mcPhase;
        logic                 machineCycle;

        // clock output pin
        logic                 clkOut;
        logic                 clkOutOe_b;

        // analog controls
        logic [5:0]           tuneOut;
        logic [1:0]           speed;
        logic                 xtalEn;

        // bus answer
        logic                 ack;
        logic [31:0]          datO;
    } occg_state_t;

    occg_state_t s_r;
    occg_state_t s_nxt;

    occg_tune_if tuneBus ();

    occg_tune_reg u_tune (
        .clk      (clk),
        .porRst_b (porRst_b),
        .tuneBus  (tuneBus.store)
    );

    logic [4:0] rawIn;
    assign rawIn = {rtcUsesCrystal, crystalInputPin, watchdogOscClock,
                    rcOscillatorClock, crystalClock};

    logic       oscLevel;
    logic       oscTick;
    logic       xtalSrc;
    logic       cloAvail;
    logic [8:0] divEnd;
    logic       divTick;
    logic       access;
    logic [9:0] regIdx;
    logic [9:0] wakeTarget;
    logic       wakeOscDone;
    logic       wakeTimeDone;
    logic       regWrite;
    logic       tuneHit;
    logic       divHit;
    logic       statHit;

    occg_pkg::occg_src_t cfgDecoded;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = rawIn;
        s_nxt.sync2 = s_r.sync1;

        // unused source codes fall back to the low-speed crystal
        case (cfgSource)
            3'h0:    cfgDecoded = occg_pkg::SRC_XTAL_LOW;
            3'h1:    cfgDecoded = occg_pkg::SRC_XTAL_MED;
            3'h2:    cfgDecoded = occg_pkg::SRC_XTAL_HIGH;
            3'h3:    cfgDecoded = occg_pkg::SRC_RC;
            3'h4:    cfgDecoded = occg_pkg::SRC_WDOG;
            3'h5:    cfgDecoded = occg_pkg::SRC_EXT;
            default: cfgDecoded = occg_pkg::SRC_XTAL_LOW;
        endcase

        // capture configuration once after reset release
        if (!s_r.cfgLoaded) begin
            s_nxt.cfgLoaded = 1'b1;
            s_nxt.srcSel    = cfgDecoded;
        end

        xtalSrc = (s_r.srcSel == occg_pkg::SRC_XTAL_LOW) ||
                  (s_r.srcSel == occg_pkg::SRC_XTAL_MED) ||
                  (s_r.srcSel == occg_pkg::SRC_XTAL_HIGH);

        // oscillator clock mux
        case (s_r.srcSel)
            occg_pkg::SRC_RC:   oscLevel = s_r.sync2[1];
            occg_pkg::SRC_WDOG: oscLevel = s_r.sync2[2];
            occg_pkg::SRC_EXT:  oscLevel = s_r.sync2[3];
            default:            oscLevel = s_r.sync2[0];
        endcase
        s_nxt.oscPrev = oscLevel;
        oscTick = oscLevel && !s_r.oscPrev && s_r.cfgLoaded;

        // crystal speed range and amplifier enable
        s_nxt.xtalEn = xtalSrc || s_r.sync2[4];
        case (s_r.srcSel)
            occg_pkg::SRC_XTAL_MED:  s_nxt.speed = 2'h1;
            occg_pkg::SRC_XTAL_HIGH: s_nxt.speed = 2'h2;
            default:                 s_nxt.speed = 2'h0;
        endcase

        // divide by 2*N, N=0 passes undivided
        divEnd  = {s_r.divN, 1'b0} - 9'h001;
        divTick = 1'b0;
        if (oscTick) begin
            if (s_r.divN == 8'h00 || s_r.divCnt >= divEnd) begin
                s_nxt.divCnt = 9'h000;
                divTick      = 1'b1;
            end else begin
                s_nxt.divCnt = s_r.divCnt + 9'h001;
            end
        end

        // wake-up timer
        wakeTarget = xtalSrc ? 10'(occg_pkg::WAKE_XTAL_OSC)
                             : 10'(occg_pkg::WAKE_OTHER_OSC);
        wakeOscDone  = (s_r.wakeOsc >= wakeTarget - 10'h001);
        wakeTimeDone = (s_r.wakeTime >= 16'(WAKE_CYCLES - 1));
        case (s_r.wake)
            occg_pkg::WAKE_COUNT_OSC: begin
                if (oscTick) begin
                    if (wakeOscDone) begin
                        s_nxt.wake    = occg_pkg::WAKE_COUNT_TIME;
                        s_nxt.wakeOsc = 10'h000;
                    end else begin
                        s_nxt.wakeOsc = s_r.wakeOsc + 10'h001;
                    end
                end
            end
            occg_pkg::WAKE_COUNT_TIME: begin
                if (wakeTimeDone) begin
                    s_nxt.wake     = occg_pkg::WAKE_RUN;
                    s_nxt.wakeTime = 16'h0000;
                end else begin
                    s_nxt.wakeTime = s_r.wakeTime + 16'h0001;
                end
            end
            default: begin
                s_nxt.wake = occg_pkg::WAKE_RUN;
            end
        endcase
        if (wakeReq) begin
            s_nxt.wake     = occg_pkg::WAKE_COUNT_OSC;
            s_nxt.wakeOsc  = 10'h000;
            s_nxt.wakeTime = 16'h0000;
        end

        // cpu clock gated until wake completes
        s_nxt.cpuTick      = divTick && (s_r.wake == occg_pkg::WAKE_RUN);
        s_nxt.machineCycle = 1'b0;
        if (s_r.cpuTick) begin
            s_nxt.periphClk    = !s_r.periphClk;
            s_nxt.mcPhase      = !s_r.mcPhase;
            s_nxt.machineCycle = s_r.mcPhase;
        end

        // clock output on crystal output pin
        cloAvail = !xtalSrc && !s_r.sync2[4] &&
                   tuneBus.tune[occg_pkg::TUNE_EN_BIT];
        s_nxt.clkOutOe_b = !cloAvail;
        if (!cloAvail) begin
            s_nxt.clkOut = 1'b0;
        end else if (s_r.cpuTick) begin
            s_nxt.clkOut = !s_r.clkOut;
        end

        s_nxt.tuneOut = tuneBus.tune[occg_pkg::TUNE_W-1:0];

        // wishbone slave, one wait state
        access   = wb_cyc_i && wb_stb_i && !s_r.ack;
        regIdx   = wb_adr_i[11:2];
        regWrite = access && wb_we_i && wb_sel_i[0];
        tuneHit  = 1'b0;
        divHit   = 1'b0;
        statHit  = 1'b0;
        if (regIdx == occg_pkg::IDX_TUNE) begin
            tuneHit = 1'b1;
        end else if (regIdx == occg_pkg::IDX_DIVIDE) begin
            divHit = 1'b1;
        end else if (regIdx == occg_pkg::IDX_STATUS) begin
            statHit = 1'b1;
        end

        // writes land on the edge that takes the request
        tuneBus.wrEn   = regWrite && tuneHit;
        tuneBus.wrData = wb_dat_i[6:0];
        if (regWrite && divHit) begin
            s_nxt.divN = wb_dat_i[7:0];
        end

        // read data stands only in the acknowledge cycle
        s_nxt.ack  = access;
        s_nxt.datO = 32'h0000_0000;
        if (access && tuneHit) begin
            s_nxt.datO[6:0] = tuneBus.tune;
        end else if (access && divHit) begin
            s_nxt.datO[7:0] = s_r.divN;
        end else if (access && statHit) begin
            s_nxt.datO[occg_pkg::STAT_SRC_LSB +: 3] = s_r.srcSel;
            s_nxt.datO[occg_pkg::STAT_RUN_BIT]      = (s_r.wake == occg_pkg::WAKE_RUN);
            s_nxt.datO[occg_pkg::STAT_CKO_BIT]      = !s_r.clkOutOe_b;
            s_nxt.datO[occg_pkg::STAT_PCLK_BIT]     = s_r.periphClk;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r            <= '0;
            s_r.srcSel     <= occg_pkg::SRC_XTAL_LOW;
            s_r.wake       <= occg_pkg::WAKE_COUNT_OSC;
            s_r.divN       <= occg_pkg::DIVIDE_RESET;
            s_r.clkOutOe_b <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o          = s_r.datO;
    assign wb_ack_o          = s_r.ack;
    assign cpuCoreClockEn    = s_r.cpuTick;
    assign periphClock       = s_r.periphClk;
    assign machineCycleEn    = s_r.machineCycle;
    assign rcTune            = s_r.tuneOut;
    assign crystalSpeed      = s_r.speed;
    assign crystalEnable     = s_r.xtalEn;
    assign crystalOutputPin  = s_r.clkOut;
    assign crystalOutputOe_b = s_r.clkOutOe_b;

endmodule

// ===== occg_pkg.sv
package occg_pkg;

    // clock and timing
    localparam int CLK_MHZ        = 100;
    localparam int WAKE_US        = 60;
    localparam int WAKE_XTAL_OSC  = 992;
    localparam int WAKE_OTHER_OSC = 224;

    // register indices (byte address is four times the index)
    localparam logic [9:0] IDX_TUNE   = 10'h096;
    localparam logic [9:0] IDX_DIVIDE = 10'h097;
    localparam logic [9:0] IDX_STATUS = 10'h098;

    // tune register layout, tune and divide register values after reset
    localparam int        TUNE_EN_BIT  = 6;
    localparam int        TUNE_W       = 6;
    localparam logic [6:0] TUNE_FACTORY = 7'h20;
    localparam logic [7:0] DIVIDE_RESET = 8'h00;

    // status register layout
    localparam int STAT_SRC_LSB  = 0;
    localparam int STAT_RUN_BIT  = 4;
    localparam int STAT_CKO_BIT  = 5;
    localparam int STAT_PCLK_BIT = 6;

    // nonvolatile oscillator source selection
    typedef enum logic [2:0] {
        SRC_XTAL_LOW,
        SRC_XTAL_MED,
        SRC_XTAL_HIGH,
        SRC_RC,
        SRC_WDOG,
        SRC_EXT
    } occg_src_t;

    typedef enum logic [1:0] {
        WAKE_COUNT_OSC,
        WAKE_COUNT_TIME,
        WAKE_RUN
    } occg_wake_t;

endpackage

// ===== occg_tune_if.sv
interface occg_tune_if;
    logic       wrEn;
    logic [6:0] wrData;
    logic [6:0] tune;

    modport ctrl (output wrEn, output wrData, input tune);
    modport store (input wrEn, input wrData, output tune);
endinterface

// ===== occg_tune_reg.sv
module occg_tune_reg (
    // clock and power-on reset
    input  wire logic  clk,
    input  wire logic  porRst_b,
    // register access
    occg_tune_if.store tuneBus
);

    typedef struct packed {
        logic [6:0] tune;
    } occg_tune_state_t;

    occg_tune_state_t s_r;
    occg_tune_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (tuneBus.wrEn) begin
            s_nxt.tune = tuneBus.wrData;
        end
    end

    // only power-on reset reloads the factory value
    always_ff @(posedge clk or negedge porRst_b) begin
        if (!porRst_b) begin
            s_r <= occg_pkg::TUNE_FACTORY;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tuneBus.tune = s_r.tune;

endmodule

// ===== occg_clock_gen_assertions.sv
module occg_clock_gen_assertions #(parameter int WAKE_CYCLES = 20) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // configuration
    input wire logic [2:0]  cfgSource,
    input wire logic        wakeReq,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // clocks
    input wire logic        cpuCoreClockEn,
    input wire logic        machineCycleEn,
    input wire logic        periphClock,
    input wire logic        crystalOutputPin,
    input wire logic        crystalOutputOe_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // oscillators run slower than clk/4, so 224 edges take over 896 cycles
    localparam int MIN_WAKE = 224 * 4 + WAKE_CYCLES;
    logic [15:0] sinceWake_r;
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b) sinceWake_r <= 16'h0;
        else if (wakeReq) sinceWake_r <= 16'h0;
        else if (sinceWake_r != 16'hffff) sinceWake_r <= sinceWake_r + 16'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat: assert property (p_dat) else $error("read data without ack");
    property p_cpu; cpuCoreClockEn |=> !cpuCoreClockEn; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu enable too long");
    property p_mcyc; machineCycleEn |-> $past(cpuCoreClockEn); endproperty
    a_mcyc: assert property (p_mcyc) else $error("machine cycle without cpu clock");
    property p_pclk; cpuCoreClockEn |=> periphClock != $past(periphClock); endproperty
    a_pclk: assert property (p_pclk) else $error("periph clock missed toggle");
    property p_phold; !cpuCoreClockEn |=> $stable(periphClock); endproperty
    a_phold: assert property (p_phold) else $error("periph clock stray toggle");
    property p_cidle; crystalOutputOe_b |-> !crystalOutputPin; endproperty
    a_cidle: assert property (p_cidle) else $error("clock out not low");
    property p_csrc; !crystalOutputOe_b |-> cfgSource inside {3'd3, 3'd4, 3'd5}; endproperty
    a_csrc: assert property (p_csrc) else $error("clock out with crystal");
    property p_wake; cpuCoreClockEn |-> int'(sinceWake_r) > MIN_WAKE; endproperty
    a_wake: assert property (p_wake) else $error("cpu clock before wake");
endmodule

bind occg_clock_gen occg_clock_gen_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
    .clk(clk), .rst_b(rst_b), .cfgSource(cfgSource), .wakeReq(wakeReq),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cpuCoreClockEn(cpuCoreClockEn), .machineCycleEn(machineCycleEn),
    .periphClock(periphClock),
    .crystalOutputPin(crystalOutputPin), .crystalOutputOe_b(crystalOutputOe_b));

// ===== occg_osc_model.sv
module occg_osc_model #(parameter int HALF_NS = 50) (
    // oscillator waveforms
    output logic crystalClock,
    output logic rcOscillatorClock,
    output logic watchdogOscClock,
    output logic crystalInputPin
);
    timeunit 1ns;
    timeprecision 1ns;
    // all sources run free; edges land on falling clk edges
    initial begin
        crystalClock = 1'b0;
        rcOscillatorClock = 1'b0;
        watchdogOscClock = 1'b0;
        crystalInputPin = 1'b0;
        forever begin
            #(HALF_NS);
            crystalClock = ~crystalClock;
            rcOscillatorClock = ~rcOscillatorClock;
            watchdogOscClock = ~watchdogOscClock;
            crystalInputPin = ~crystalInputPin;
        end
    end
endmodule

// ===== occg_clock_gen_tb.sv
module occg_clock_gen_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE = 20;
    logic        clk, rst_b, porRst_b, rtcUsesCrystal, wakeReq, xc, rc, wd, xi;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpuCoreClockEn, periphClock;
    logic        machineCycleEn, crystalEnable, crystalOutputPin, crystalOutputOe_b;
    logic [2:0]  cfgSource;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [3:0]  wbSel = 4'h1;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [5:0]  rcTune;
    logic [1:0]  crystalSpeed;
    int          fails = 0;
    int          samplesChecked = 0;
    occg_osc_model occg_osc_model_i (.crystalClock(xc), .rcOscillatorClock(rc),
        .watchdogOscClock(wd), .crystalInputPin(xi));
    occg_clock_gen #(.WAKE_CYCLES(WAKE)) occg_clock_gen_i (.clk(clk), .rst_b(rst_b),
        .porRst_b(porRst_b), .cfgSource(cfgSource), .rtcUsesCrystal(rtcUsesCrystal),
        .wakeReq(wakeReq), .crystalClock(xc), .rcOscillatorClock(rc),
        .watchdogOscClock(wd), .crystalInputPin(xi), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cpuCoreClockEn(cpuCoreClockEn), .periphClock(periphClock),
        .machineCycleEn(machineCycleEn), .rcTune(rcTune), .crystalSpeed(crystalSpeed),
        .crystalEnable(crystalEnable), .crystalOutputPin(crystalOutputPin),
        .crystalOutputOe_b(crystalOutputOe_b));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic timeout_hit();
        fails++;
        $display("MISMATCH %0t wait ran out", $time);
        finish_test();
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= wbSel;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) timeout_hit();
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wait_cpu(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cpuCoreClockEn !== 1'b1 && n < 20000);
        if (n >= 20000) timeout_hit();
    endtask
    task automatic do_reset(input logic por);
        rst_b <= 1'b0;
        porRst_b <= !por;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        porRst_b <= 1'b1;
    endtask
    task automatic test_sources();
        int n;
        int osc;
        int src;
        logic [31:0] q;
        // code 6 is unused and behaves as the low-speed crystal
        for (int s = 0; s < 7; s++) begin
            cfgSource <= 3'(s);
            do_reset(1'b1);
            src = (s == 6) ? 0 : s;
            osc = (src < 3) ? 992 : 224;
            wait_cpu(n);
            check(32'(n > osc * 10 + WAKE - 10 && n < osc * 10 + WAKE + 60), 32'h1);
            check(32'(crystalEnable), 32'(src < 3));
            if (src < 3) check(32'(crystalSpeed), 32'(src));
            wb(1'b0, 12'h260, 32'h0, q);
            check(32'(q[2:0]), 32'(src));
        end
        $display("sources done");
    endtask
    task automatic test_tune();
        logic [31:0] q;
        wb(1'b0, 12'h258, 32'h0, q);
        check(q, 32'h20);
        wb(1'b1, 12'h258, 32'hff, q);
        wb(1'b0, 12'h258, 32'h0, q);
        check(q, 32'h7f);
        check(32'(rcTune), 32'h3f);
        wbSel = 4'h0;
        wb(1'b1, 12'h258, 32'h00, q);
        wbSel = 4'h1;
        wb(1'b0, 12'h258, 32'h0, q);
        check(q, 32'h7f);
        wb(1'b0, 12'h3fc, 32'h0, q);
        check(q, 32'h0);
        do_reset(1'b0);
        wb(1'b0, 12'h258, 32'h0, q);
        check(q, 32'h7f);
        do_reset(1'b1);
        wb(1'b0, 12'h258, 32'h0, q);
        check(q, 32'h20);
        $display("tune done");
    endtask
    task automatic test_clocks();
        int n, cpu, pt, mcn, ck;
        logic [31:0] q;
        logic lastP, lastC;
        cfgSource <= 3'd3;
        do_reset(1'b1);
        wait_cpu(n);
        wb(1'b1, 12'h25c, 32'h2, q);
        wb(1'b1, 12'h258, 32'h60, q);
        repeat (3) wait_cpu(n);
        check(32'(n), 32'd40);
        cpu = 0;
        pt = 0;
        mcn = 0;
        ck = 0;
        lastP = periphClock;
        lastC = crystalOutputPin;
        repeat (400) begin
            @(posedge clk);
            cpu += cpuCoreClockEn;
            mcn += machineCycleEn;
            pt += (periphClock != lastP);
            ck += (crystalOutputPin != lastC);
            lastP = periphClock;
            lastC = crystalOutputPin;
        end
        check(32'(cpu inside {[9:11]}), 32'h1);
        check(32'((pt - cpu) inside {[-1:1]}), 32'h1);
        check(32'((2 * mcn - cpu) inside {[-2:2]}), 32'h1);
        check(32'((ck - cpu) inside {[-1:1]}), 32'h1);
        check(32'(crystalOutputOe_b), 32'h0);
        wb(1'b0, 12'h260, 32'h0, q);
        check(32'(q[5:0]), 32'h33);
        rtcUsesCrystal <= 1'b1;
        repeat (8) @(posedge clk);
        check(32'(crystalOutputOe_b), 32'h1);
        rtcUsesCrystal <= 1'b0;
        wb(1'b1, 12'h258, 32'h20, q);
        repeat (8) @(posedge clk);
        check(32'(crystalOutputOe_b), 32'h1);
        $display("clocks done");
    endtask
    task automatic test_wake();
        int n;
        logic [31:0] q;
        wakeReq <= 1'b1;
        @(posedge clk);
        wakeReq <= 1'b0;
        wb(1'b0, 12'h260, 32'h0, q);
        check(32'(q[5:0]), 32'h03);
        wait_cpu(n);
        check(32'(n > 224 * 10 + WAKE - 20 && n < 224 * 10 + WAKE + 80), 32'h1);
        wb(1'b0, 12'h260, 32'h0, q);
        check(32'(q[5:0]), 32'h13);
        $display("wake done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rtcUsesCrystal <= 1'b0;
        wakeReq <= 1'b0;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_sel_i <= 4'h0;
        wb_adr_i <= 12'h0;
        wb_dat_i <= 32'h0;
        test_sources();
        test_tune();
        test_clocks();
        test_wake();
        finish_test();
    end
endmodule
